// ---- rtl/fbp_pkg.sv ----
// Purpose: Shared types and constants of the radix-2 butterfly pipeline.
// Assumes: Q15 fixed-point halves; eight-register file split in two banks.
// Notes:   Each constant is defined here once; some files repeat its value as a literal.
`default_nettype none
package fbp_pkg;
	localparam int HALF_W    = 16;
	localparam int ADDR_W    = 10;
	localparam int CNT_W     = 10;
	localparam int STAGES    = 9;
	localparam int PIPE_N    = 4;
	localparam int FIFO_DEP  = 16;
	localparam int FIFO_ROOM = 10;
	// Distance between the p and q halves of a first-stage pair.
	localparam logic [ADDR_W-1:0] Q_OFFSET   = 10'h200;
	localparam logic [HALF_W-1:0] W_UNITY_RE = 16'h7fff;
	localparam logic [HALF_W-1:0] W_UNITY_IM = 16'h0000;
	// Register slot inside a bank; the bank bit sits above it.
	localparam logic [1:0] RF_Q_RE = 2'h0;
	localparam logic [1:0] RF_Q_IM = 2'h1;
	localparam logic [1:0] RF_W_RE = 2'h2;
	localparam logic [1:0] RF_W_IM = 2'h3;

	// A complex word: real half above imaginary half.
	typedef struct packed {
		logic [HALF_W-1:0] re;
		logic [HALF_W-1:0] im;
	} fbp_cplx_t;

	typedef struct packed {
		fbp_cplx_t p;
		fbp_cplx_t q;
		fbp_cplx_t w;
	} fbp_opnd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		fbp_cplx_t         data;
	} fbp_wreq_t;

	typedef struct packed {
		fbp_cplx_t         p;
		logic [ADDR_W-1:0] k;
	} fbp_pstage_t;

	// Port commands of the register file: two write ports, three read ports.
	typedef struct packed {
		logic              wb_en;
		logic              wc_en;
		logic [2:0]        wb_addr;
		logic [2:0]        wc_addr;
		logic [HALF_W-1:0] wb_data;
		logic [HALF_W-1:0] wc_data;
		logic [2:0]        ra;
		logic [2:0]        rd;
		logic [2:0]        re;
	} fbp_rf_cmd_t;

	// Horizontal microword: every unit has its own field.
	typedef struct packed {
		logic wr_q;
		logic wr_w;
		logic bk_w;
		logic rd_qim;
		logic rd_qre;
		logic bk_r;
		logic mac_ld1;
		logic mac_ld2;
		logic mac_mul;
		logic mac_acc;
		logic p_shift;
		logic alu_sub;
		logic alu_add;
	} fbp_uword_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_RUN   = 2'b01,
		SEQ_DRAIN = 2'b10,
		SEQ_DONE  = 2'b11
	} fbp_seq_t;
endpackage : fbp_pkg
`default_nettype wire

// ---- rtl/fbp_fifo.sv ----
// Purpose: Result FIFO between the butterfly pipeline and the data RAM.
// Assumes: DEPTH of at least two.
// Notes:   Output data comes straight from the storage flip-flops.
`timescale 1ns/100ps
`default_nettype none
module fbp_fifo #(
	parameter int W     = 42,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_n,
	// Filling side.
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire logic [W-1:0]               i_in_data,
	// Draining side.
	output logic                            o_out_valid,
	input  wire logic                       i_out_ready,
	output logic [W-1:0]                    o_out_data,
	// Fill level.
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} fbp_fifo_st_t;

	fbp_fifo_st_t st;
	fbp_fifo_st_t next_st;
	logic         push;
	logic         pop;

	// Handshakes and the storage read port.
	assign o_in_ready  = (st.cnt != CW'(DEPTH));
	assign o_out_valid = (st.cnt != '0);
	assign o_out_data  = st.mem[st.rp];
	assign o_count     = st.cnt;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// Pointer and level update.
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = i_in_data;
			next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
		end
		next_st.cnt = st.cnt + CW'(push) - CW'(pop);
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	chk_fifo_full_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st.cnt == CW'(DEPTH)) && !pop |=> st.cnt == CW'(DEPTH))
		else $error("FIFO level changed while full without a pop.");
endmodule : fbp_fifo
`default_nettype wire

// ---- rtl/fbp_regfile.sv ----
// Purpose: Eight-register multiport file with two write and three read ports.
// Assumes: Commands arrive one cycle before they act.
// Notes:   A read in the cycle of a write to the same register sees old data.
`timescale 1ns/100ps
`default_nettype none
module fbp_regfile
	import fbp_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	// Port commands.
	input  wire fbp_rf_cmd_t       i_cmd,
	// Read data of ports A, D and E.
	output logic [HALF_W-1:0]      o_rd_a,
	output logic [HALF_W-1:0]      o_rd_d,
	output logic [HALF_W-1:0]      o_rd_e
);
	typedef struct packed {
		logic [7:0][HALF_W-1:0] mem;
		fbp_rf_cmd_t            cmd;
	} fbp_rf_st_t;

	fbp_rf_st_t st;
	fbp_rf_st_t next_st;

	// Read ports use the captured addresses and the array before this edge.
	assign o_rd_a = st.mem[st.cmd.ra];
	assign o_rd_d = st.mem[st.cmd.rd];
	assign o_rd_e = st.mem[st.cmd.re];

	// Captured commands write the array one period after capture.
	always_comb begin
		next_st = st;
		next_st.cmd = i_cmd;
		if (st.cmd.wb_en) begin
			next_st.mem[st.cmd.wb_addr] = st.cmd.wb_data;
		end
		if (st.cmd.wc_en) begin
			next_st.mem[st.cmd.wc_addr] = st.cmd.wc_data;
		end
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : fbp_regfile
`default_nettype wire

// ---- rtl/fbp_butterfly_pipeline.sv ----
// Purpose: Microcoded radix-2 DIT butterfly datapath with in-place results.
// Assumes: Operands stream in pair order; results drain to the data RAM.
// Notes:   One butterfly issues every two cycles while operands and room allow.
`timescale 1ns/100ps
`default_nettype none
module fbp_butterfly_pipeline
	import fbp_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEP
) (
	// Clock and reset.
	input  wire logic              i_core_clk,
	input  wire logic              i_arst_n,
	// Host start code and status.
	input  wire logic              i_start,
	input  wire logic [CNT_W-1:0]  i_bfly_last,
	output logic                   o_busy,
	output logic                   o_done,
	// Operands from the complex operand store.
	input  wire logic              i_opnd_valid,
	input  wire fbp_opnd_t         i_opnd,
	output logic                   o_opnd_ready,
	// In-place result writes to the data RAM.
	output logic                   o_wr_valid,
	output fbp_wreq_t              o_wr,
	input  wire logic              i_wr_ready
);
	localparam int CW = $clog2(FIFO_DEPTH+1);

	typedef struct packed {
		fbp_seq_t                   seq;
		logic                       ph;
		logic [CNT_W-1:0]           left;
		logic [ADDR_W-1:0]          k;
		logic [STAGES-1:0]          tok;
		logic [STAGES-1:0]          tb;
		fbp_opnd_t                  hold;
		logic [ADDR_W-1:0]          hold_k;
		fbp_uword_t                 uir;
		logic [PIPE_N-1:0][ADDR_W+31:0] pipe;
		logic signed [HALF_W-1:0]   in1a;
		logic signed [HALF_W-1:0]   in1b;
		logic signed [HALF_W-1:0]   in2a;
		logic signed [HALF_W-1:0]   in2b;
		logic signed [31:0]         acc1;
		logic signed [31:0]         acc2;
		logic [HALF_W-1:0]          out1;
		logic [HALF_W-1:0]          out2;
		logic                       res_v;
		logic                       res_is_q;
		fbp_wreq_t                  res;
	} fbp_st_t;

	fbp_st_t          st;
	fbp_st_t          next_st;
	logic [1:0]       rst_sync;
	logic             rst_n;
	logic             issue;
	logic             room;
	logic             fifo_in_ready;
	logic [CW-1:0]    fifo_cnt;
	fbp_rf_cmd_t      rf_cmd;
	logic [HALF_W-1:0] rd_a;
	logic [HALF_W-1:0] rd_d;
	logic [HALF_W-1:0] rd_e;
	fbp_pstage_t      p_use;

	// Decode the token vector into one horizontal microword.
	function automatic fbp_uword_t fbp_decode(input logic [STAGES-1:0] tok,
		input logic [STAGES-1:0] tb);
		fbp_uword_t u;
		u = '0;
		u.wr_q    = tok[0];
		u.wr_w    = tok[1];
		u.bk_w    = tok[0] ? tb[0] : tb[1];
		u.rd_qim  = tok[2];
		u.rd_qre  = tok[3];
		u.bk_r    = tok[2] ? tb[2] : tb[3];
		u.mac_ld1 = tok[3];
		u.mac_ld2 = tok[4];
		u.mac_mul = tok[4];
		u.mac_acc = tok[5];
		u.p_shift = tok[1] | tok[3] | tok[5] | tok[7];
		u.alu_sub = tok[6];
		u.alu_add = tok[7];
		return u;
	endfunction : fbp_decode

	// Signed Q15 product, widened for accumulation.
	function automatic logic signed [32:0] fbp_mul(input logic signed [HALF_W-1:0] a,
		input logic signed [HALF_W-1:0] b);
		logic signed [31:0] m;
		m = a * b;
		return {m[31], m};
	endfunction : fbp_mul

	// Reset release through two flip-flops.
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Issue only in the even slot with operands and room for all results.
	assign room         = (fifo_cnt <= CW'(FIFO_DEPTH - FIFO_ROOM));
	assign o_opnd_ready = (st.seq == SEQ_RUN) && !st.ph && room;
	assign issue        = o_opnd_ready && i_opnd_valid;
	assign o_busy       = (st.seq != SEQ_IDLE);
	assign o_done       = (st.seq == SEQ_DONE);
	assign p_use        = fbp_pstage_t'(st.pipe[2]);

	// Register file commands follow the microinstruction register.
	always_comb begin
		rf_cmd = '0;
		if (st.uir.wr_q) begin
			rf_cmd.wb_en   = 1'b1;
			rf_cmd.wc_en   = 1'b1;
			rf_cmd.wb_addr = {st.uir.bk_w, RF_Q_RE};
			rf_cmd.wc_addr = {st.uir.bk_w, RF_Q_IM};
			rf_cmd.wb_data = st.hold.q.re;
			rf_cmd.wc_data = st.hold.q.im;
		end else if (st.uir.wr_w) begin
			rf_cmd.wb_en   = 1'b1;
			rf_cmd.wc_en   = 1'b1;
			rf_cmd.wb_addr = {st.uir.bk_w, RF_W_RE};
			rf_cmd.wc_addr = {st.uir.bk_w, RF_W_IM};
			rf_cmd.wb_data = st.hold.w.re;
			rf_cmd.wc_data = st.hold.w.im;
		end
		// Port A picks the q half; D and E keep pointing at the twiddle.
		rf_cmd.ra = {st.uir.bk_r, st.uir.rd_qim ? RF_Q_IM : RF_Q_RE};
		rf_cmd.rd = {st.uir.bk_r, RF_W_RE};
		rf_cmd.re = {st.uir.bk_r, RF_W_IM};
	end

	fbp_regfile u_regfile (
		.i_clk   (i_core_clk),
		.i_rst_n (rst_n),
		.i_cmd   (rf_cmd),
		.o_rd_a  (rd_a),
		.o_rd_d  (rd_d),
		.o_rd_e  (rd_e)
	);

	fbp_fifo #(
		.W     ($bits(fbp_wreq_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_core_clk),
		.i_rst_n     (rst_n),
		.i_in_valid  (st.res_v),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (st.res),
		.o_out_valid (o_wr_valid),
		.i_out_ready (i_wr_ready),
		.o_out_data  (o_wr),
		.o_count     (fifo_cnt)
	);

	// Sequencer, operand capture, MACs, pipeline register and ALUs.
	always_comb begin
		next_st = st;
		next_st.ph  = (st.seq == SEQ_RUN) ? ~st.ph : 1'b0;
		next_st.tok = {st.tok[STAGES-2:0], issue};
		next_st.tb  = {st.tb[STAGES-2:0], st.k[0]};
		next_st.uir = fbp_decode(next_st.tok, next_st.tb);
		unique case (st.seq)
			SEQ_IDLE: begin
				if (i_start) begin
					next_st.seq  = SEQ_RUN;
					next_st.left = i_bfly_last;
					next_st.k    = '0;
				end
			end
			SEQ_RUN: begin
				if (issue) begin
					next_st.k = st.k + 1'b1;
					next_st.left = st.left - 1'b1;
					if (st.left == '0) begin
						next_st.seq = SEQ_DRAIN;
					end
				end
			end
			SEQ_DRAIN: begin
				if (st.tok == '0 && !st.res_v && fifo_cnt == '0) begin
					next_st.seq = SEQ_DONE;
				end
			end
			SEQ_DONE: begin
				next_st.seq = SEQ_IDLE;
			end
		endcase
		// Twiddle and p are taken from the operand store together.
		if (issue) begin
			next_st.hold   = i_opnd;
			next_st.hold_k = st.k;
			if (st.k == '0) begin
				next_st.hold.w = {W_UNITY_RE, W_UNITY_IM};
			end
		end
		// The p operand steps down on even slots and holds on odd ones.
		if (st.uir.p_shift) begin
			next_st.pipe[PIPE_N-1:1] = st.pipe[PIPE_N-2:0];
			next_st.pipe[0] = st.uir.wr_w ? {st.hold.p, st.hold_k} : '0;
		end
		// First operand pairs share the imaginary q half.
		if (st.uir.mac_ld1) begin
			next_st.in1a = rd_e;
			next_st.in1b = rd_a;
			next_st.in2a = rd_d;
			next_st.in2b = rd_a;
		end else if (st.uir.mac_ld2) begin
			next_st.in1a = rd_d;
			next_st.in1b = rd_a;
			next_st.in2a = rd_e;
			next_st.in2b = rd_a;
		end
		if (st.uir.mac_mul) begin
			next_st.acc1 = st.in1a * st.in1b;
			next_st.acc2 = st.in2a * st.in2b;
		end
		if (st.uir.mac_acc) begin
			next_st.out1 = 16'((fbp_mul(st.in1a, st.in1b) - {st.acc1[31], st.acc1}) >>> 15);
			next_st.out2 = 16'((fbp_mul(st.in2a, st.in2b) + {st.acc2[31], st.acc2}) >>> 15);
		end
		// The ALUs form new q, then new p from the held operands.
		next_st.res_v = st.uir.alu_sub | st.uir.alu_add;
		next_st.res_is_q = st.uir.alu_sub;
		if (st.uir.alu_sub) begin
			next_st.res.data.re = p_use.p.re - st.out1;
			next_st.res.data.im = p_use.p.im - st.out2;
			next_st.res.addr = p_use.k + Q_OFFSET;
		end else if (st.uir.alu_add) begin
			next_st.res.data.re = p_use.p.re + st.out1;
			next_st.res.data.im = p_use.p.im + st.out2;
			next_st.res.addr = p_use.k;
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_rf_load;
		st.uir.wr_q ##1 st.uir.wr_w;
	endsequence
	sequence seq_mac_steps;
		st.uir.mac_ld1 ##1 (st.uir.mac_mul && st.uir.mac_ld2) ##1 st.uir.mac_acc;
	endsequence

	chk_issue_gap: assert property (issue |=> !issue)
		else $error("Two butterflies issued back to back.");
	chk_first_latency: assert property (issue |-> ##8 (st.res_v && st.res_is_q))
		else $error("New q did not appear eight cycles after issue.");
	chk_q_addr_slot: assert property (st.uir.wr_q |-> rf_cmd.wb_addr[1:0] == RF_Q_RE && rf_cmd.wc_addr[1:0] == RF_Q_IM)
		else $error("Write ports not aimed at the q halves.");
	chk_rf_load_order: assert property (st.uir.wr_q |-> seq_rf_load)
		else $error("Twiddle write did not follow the q write.");
	chk_mac_steps: assert property (st.uir.mac_ld1 |-> seq_mac_steps)
		else $error("MAC load, multiply and accumulate out of order.");
	chk_pipe_hold: assert property (st.uir.alu_sub |=> $stable(st.pipe[2]) && st.uir.alu_add)
		else $error("Pipeline p operand moved between new q and new p.");
	chk_in_place: assert property (st.res_v && st.res_is_q |=> st.res_v && !st.res_is_q && st.res.addr == $past(st.res.addr) - Q_OFFSET)
		else $error("New p not written to its own place after new q.");
	chk_first_twiddle: assert property (issue && st.k == '0 |=> st.hold.w.re == W_UNITY_RE && st.hold.w.im == W_UNITY_IM)
		else $error("First butterfly twiddle is not unity.");
	chk_drain_done: assert property (st.seq == SEQ_DONE |-> st.tok == '0 && !st.res_v && fifo_cnt == '0)
		else $error("Completion signalled before the pipeline drained.");
	chk_no_overrun: assert property (st.res_v |-> fifo_in_ready)
		else $error("Result produced while the FIFO was full.");
endmodule : fbp_butterfly_pipeline
`default_nettype wire

// ---- testbench/fbp_store_model.sv ----
// Purpose: Far-side model of the operand store and the complex data RAM.
// Assumes: The bench queues operand triples in pair order before a run.
// Notes:   An idle operand bus inverts each cycle, so every second idle cycle shows the last triple again.
`timescale 1ns/100ps
`default_nettype none
module fbp_store_model
	import fbp_pkg::*;
(
	// Clock and reset.
	input  wire logic      i_clk,
	input  wire logic      i_arst_n,
	// Pacing from the bench.
	input  wire logic      i_src_go,
	input  wire logic      i_sink_go,
	// Operand side.
	output logic           o_opnd_valid,
	output fbp_opnd_t      o_opnd,
	input  wire logic      i_opnd_ready,
	// Write side.
	input  wire logic      i_wr_valid,
	input  wire fbp_wreq_t i_wr,
	output logic           o_wr_ready
);
	fbp_opnd_t         opq[$];
	fbp_cplx_t         mem[0:1023];
	logic [ADDR_W-1:0] wlog[$];

	// Offers p, q and twiddle together and holds them until taken.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_opnd_valid <= 1'b0;
			o_opnd       <= '0;
		end else if (o_opnd_valid && !i_opnd_ready) begin
			o_opnd_valid <= 1'b1;
		end else begin
			if (o_opnd_valid) begin
				void'(opq.pop_front());
			end
			if (opq.size() > 0 && i_src_go) begin
				o_opnd_valid <= 1'b1;
				o_opnd       <= opq[0];
			end else begin
				o_opnd_valid <= 1'b0;
				o_opnd       <= ~o_opnd;
			end
		end
	end

	// Stores each accepted result at its own address and logs the order.
	always @(posedge i_clk) begin
		o_wr_ready <= i_sink_go;
		if (i_wr_valid && o_wr_ready) begin
			mem[i_wr.addr] <= i_wr.data;
			wlog.push_back(i_wr.addr);
		end
	end
endmodule : fbp_store_model
`default_nettype wire

// ---- testbench/fbp_butterfly_pipeline_tb.sv ----
// Purpose: Self-checking bench of the butterfly pipeline against a queue model.
// Assumes: Truncated Q15 products summed before the cut, as the hand-over states.
// Notes:   Three runs: free flow, random stalls, and a long stall of the RAM.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module fbp_butterfly_pipeline_tb
	import fbp_pkg::*;
;
	logic              clk = 1'b0;
	logic              arst_n, start, src_go, sink_go;
	logic [CNT_W-1:0]  last;
	logic              busy, done, opnd_valid, opnd_ready, wr_valid, wr_ready;
	fbp_opnd_t         opnd;
	fbp_wreq_t         wr;
	int                num_errors = 0;
	int                checks_done = 0;
	int                cyc = 0;
	int                first_take, last_take, first_wr, ntake;
	bit                nostall;
	logic [31:0]       seed = 32'h58cb;
	fbp_cplx_t         exp_mem[0:1023];

	fbp_butterfly_pipeline #(.FIFO_DEPTH(FIFO_DEP)) i_fbp_butterfly_pipeline (
		.i_core_clk(clk), .i_arst_n(arst_n), .i_start(start), .i_bfly_last(last),
		.o_busy(busy), .o_done(done), .i_opnd_valid(opnd_valid), .i_opnd(opnd),
		.o_opnd_ready(opnd_ready), .o_wr_valid(wr_valid), .o_wr(wr), .i_wr_ready(wr_ready));
	fbp_store_model i_fbp_store_model (
		.i_clk(clk), .i_arst_n(arst_n), .i_src_go(src_go), .i_sink_go(sink_go),
		.o_opnd_valid(opnd_valid), .o_opnd(opnd), .i_opnd_ready(opnd_ready),
		.i_wr_valid(wr_valid), .i_wr(wr), .o_wr_ready(wr_ready));

	// Free-running 40 MHz clock.
	always #12.5 clk = ~clk;

	// Xorshift source for operands and stalls.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Reference butterfly: q' = p - q*w and p' = p + q*w, product bits 30 to 15.
	function automatic fbp_cplx_t bfly(fbp_cplx_t p, fbp_cplx_t q, fbp_cplx_t w, bit isq);
		longint    xr, xi;
		fbp_cplx_t r;
		xr = longint'($signed(q.re)) * $signed(w.re) - longint'($signed(q.im)) * $signed(w.im);
		xi = longint'($signed(q.re)) * $signed(w.im) + longint'($signed(q.im)) * $signed(w.re);
		xr = xr >>> 15;
		xi = xi >>> 15;
		r.re = isq ? p.re - xr[15:0] : p.re + xr[15:0];
		r.im = isq ? p.im - xi[15:0] : p.im + xi[15:0];
		return r;
	endfunction : bfly

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// Watches operand takes and the first result for spacing and latency.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (opnd_valid === 1'b1 && opnd_ready === 1'b1) begin
			if (ntake == 0) begin
				first_take = cyc;
			end else if (nostall) begin
				`CHK("issue spacing", 2, cyc - last_take);
			end
			last_take = cyc;
			ntake++;
		end
		if (wr_valid === 1'b1 && first_wr < 0) begin
			first_wr = cyc;
		end
	end

	// One transform of n butterflies; mode 0 free, 1 random stalls, 2 RAM stall.
	task automatic run(input int n, input int mode);
		fbp_opnd_t   op;
		fbp_cplx_t   w;
		logic [31:0] r;
		int          k;
		for (int i = 0; i < n; i++) begin
			op = {rnd(), rnd(), rnd()};
			if (i == 1) begin
				op.q = 32'h80008000;
			end
			w = (i == 0) ? {W_UNITY_RE, W_UNITY_IM} : op.w;
			exp_mem[i + Q_OFFSET] = bfly(op.p, op.q, w, 1'b1);
			exp_mem[i] = bfly(op.p, op.q, w, 1'b0);
			i_fbp_store_model.opq.push_back(op);
		end
		i_fbp_store_model.wlog.delete();
		nostall = (mode == 0);
		ntake = 0;
		first_wr = -1;
		src_go = 1'b1;
		sink_go = (mode != 2);
		last = 10'(n - 1);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
			r = rnd();
			start = (k == 5);
			last = (k == 5) ? '0 : 10'(n - 1);
			if (mode == 1) begin
				src_go = |r[1:0];
				sink_go = |r[3:2];
			end
			if (mode == 2 && k == 80) begin
				`CHK("ready while full", 1'b0, opnd_ready);
				`CHK("pending write", 1'b1, wr_valid);
				sink_go = 1'b1;
			end
		end
		if (k >= 4000) begin
			num_errors++;
			$display("ERROR done not seen");
			wrap_up();
		end
		`CHK("busy with done", 1'b1, busy);
		@(negedge clk);
		`CHK("done width", 1'b0, done);
		`CHK("busy after done", 1'b0, busy);
		`CHK("takes", n, ntake);
		`CHK("write count", 2 * n, i_fbp_store_model.wlog.size());
		if (mode == 0) begin
			`CHK("q latency", 9, first_wr - first_take);
		end
		for (int i = 0; i < n; i++) begin
			`CHK("q addr", 10'(i) + Q_OFFSET, i_fbp_store_model.wlog[2 * i]);
			`CHK("p addr", 10'(i), i_fbp_store_model.wlog[2 * i + 1]);
			`CHK("q data", exp_mem[i + 512], i_fbp_store_model.mem[i + 512]);
			`CHK("p data", exp_mem[i], i_fbp_store_model.mem[i]);
		end
	endtask : run

	// Reset for 12 cycles, then the three runs.
	initial begin
		arst_n = 1'b0;
		start = 1'b0;
		last = '0;
		src_go = 1'b0;
		sink_go = 1'b1;
		repeat (12) @(negedge clk);
		`CHK("busy in reset", 1'b0, busy);
		`CHK("ready in reset", 1'b0, opnd_ready);
		`CHK("write in reset", 1'b0, wr_valid);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		run(8, 0);
		run(24, 1);
		run(12, 2);
		wrap_up();
	end
endmodule : fbp_butterfly_pipeline_tb
`undef CHK
`default_nettype wire
